//--- design/anwm_pkg.sv
// Purpose: constants and carrier types for the async word memory host controller
// Assumes: sys_clk at 125 MHz, synchronous active-high reset
// Notes: all cycle counts except SYNC_LAT_CYC derive from the printed ns and ms figures and the clock period
// Overview of operation
// R01: the memory holds 65,536 words of 16 bits, one per address value.
// R02: with select high the memory ignores every other control and floats both lanes.
// R03: selected with write and output gate high, or both lane selects high, nothing is accessed.
// R04: a read with only the lower lane select low returns the lower byte on bits 7:0.
// R05: a read with only the upper lane select low returns the upper byte on bits 15:8.
// R06: a read with both lane selects low returns the whole 16-bit word.
// R07: a write with only the lower lane select low stores bits 7:0 and keeps the upper byte.
// R08: a write with only the upper lane select low stores bits 15:8 and keeps the lower byte.
// R09: a write with both lane selects low stores the whole word and the memory does not drive.
// R10: the memory refuses all writes while supply is below the write inhibit level.
// R11: the controller starts no access until 2 ms after supply becomes valid.
// R12: the controller holds select and write strobe high during reset and the startup wait.
// R13: after a brownout the controller waits the full startup time again.
// R14: consecutive accesses start no closer than 35 ns apart.
// R15: a write happens while select and write strobe are both low, with address and data held.
// R16: the memory commits write data at the end of the select and write strobe overlap.
package anwm_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int MEM_WORDS = 65536;
  // timing figures as printed, then cycle counts (least times round up)
  localparam int STARTUP_MS = 2;
  localparam int CYCLE_NS = 35;
  localparam int ACCESS_NS = 35;
  localparam int WR_PULSE_NS = 18;
  localparam int RECOVERY_NS = 15;
  localparam int STARTUP_CYC = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT_CYC = 3;
  localparam int CNT_W = 20;
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // one user request
  typedef struct packed {
    logic write;
    logic [LANES-1:0] lane_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } anwm_req_t;

  // memory control pins, all active low
  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic oe_n;
    logic lower_lane_select_low;
    logic upper_lane_select_low;
  } anwm_ctl_t;

  localparam anwm_ctl_t CTL_IDLE = 5'h1F;

  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_IDLE = 5'h02,
    ST_READ = 5'h04,
    ST_WRITE = 5'h08,
    ST_RECOV = 5'h10
  } anwm_state_t;
endpackage

//--- design/anwm_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk
// Notes: each output bit moves only when its stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module anwm_sync
  import anwm_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  // per-bit agreement, so a lane that keeps moving cannot freeze the steady one
  wire [W-1:0] agree = ~(s2_ff ^ s3_ff);

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= (agree & s3_ff) | (~agree & out_ff);
    end
  end

  assign sync_out = out_ff;
endmodule
`default_nettype wire

//--- design/anwm_host.sv
// Purpose: host controller driving an asynchronous non-volatile 64K x 16 word memory
// Assumes: one request at a time; supply_ok is a board-level supply-valid level
// Notes: all memory pins come from flip-flops; data lanes float except from the start of a write to the end of its recovery
`timescale 1ns/1ps
`default_nettype none
module anwm_host
  import anwm_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // supply monitor, asynchronous
  input wire logic supply_ok,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire anwm_req_t req,
  // user response
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic mem_ready,
  // memory pins
  output anwm_ctl_t mem_ctl,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [DATA_W-1:0] dq_in
);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(ACCESS_CYC + SYNC_LAT_CYC - 1);
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVERY_CYC - 1);

  anwm_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  anwm_ctl_t ctl_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dout_ff;
  logic drive_n_ff;
  logic rsp_valid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [LANES-1:0] lanes_ff;
  logic supply_s;
  logic [DATA_W-1:0] dq_s;

  // supply level and read data both cross in from pins
  anwm_sync #(.W(1)) u_sync_supply (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(supply_ok),
    .sync_out(supply_s)
  );
  anwm_sync #(.W(DATA_W)) u_sync_data (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(dq_in),
    .sync_out(dq_s)
  );

  // lane byte mask, used for both launch and capture
  function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] en);
    lane_mask = {{BYTE_W{en[1]}}, {BYTE_W{en[0]}}};
  endfunction

  // decode of the current cycle
  wire in_init = (state_ff == ST_INIT);
  wire brownout = !supply_s && !in_init;
  wire take = req_valid && req_ready;
  wire no_lane = (req.lane_en == LANES_NONE);
  wire wr_done = (state_ff == ST_WRITE) && (cnt_ff == WR_LAST);
  wire rd_done = (state_ff == ST_READ) && (cnt_ff == RD_LAST);
  wire rec_done = (state_ff == ST_RECOV) && (cnt_ff == REC_LAST);
  wire boot_done = in_init && supply_s && (cnt_ff == STARTUP_LAST);
  wire [DATA_W-1:0] rd_mask = lane_mask(lanes_ff);

  assign req_ready = (state_ff == ST_IDLE) && supply_s; // see R11
  assign mem_ready = !in_init;

  // next state
  anwm_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_INIT: if (boot_done) nxt_state = ST_IDLE; // see R11
      ST_IDLE: if (take && !no_lane) nxt_state = req.write ? ST_WRITE : ST_READ; // see R03
      ST_WRITE: if (wr_done) nxt_state = ST_RECOV;
      ST_READ: if (rd_done) nxt_state = ST_RECOV;
      ST_RECOV: if (rec_done) nxt_state = ST_IDLE; // see R14
      default: nxt_state = ST_INIT;
    endcase
    if (brownout) begin
      nxt_state = ST_INIT; // see R13
    end
  end

  // counter restarts on each state change; startup count restarts on supply loss
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_INIT;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || (in_init && !supply_s)) begin
        cnt_ff <= '0; // see R13
      end else if (!boot_done) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // pin drivers; select and strobe stay high until startup completes
  always_ff @(posedge sys_clk) begin
    if (rst || brownout) begin
      ctl_ff <= CTL_IDLE; // see R12
      drive_n_ff <= 1'b1;
    end else if (state_ff == ST_IDLE && take && !no_lane) begin
      ctl_ff.sel_n <= 1'b0;
      ctl_ff.wr_n <= !req.write; // see R15
      ctl_ff.oe_n <= req.write; // gate high on writes avoids contention, see R09
      ctl_ff.lower_lane_select_low <= !req.lane_en[0]; // see R04
      ctl_ff.upper_lane_select_low <= !req.lane_en[1]; // see R05
      drive_n_ff <= !req.write;
    end else if (wr_done || rd_done) begin
      ctl_ff <= CTL_IDLE; // write commits on this rising edge, see R16
    end else if (rec_done) begin
      drive_n_ff <= 1'b1; // data held past strobe release, see R15
    end
  end

  // address, write data and lanes latch on acceptance and hold through recovery
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_ff <= ADDR_RST;
      dout_ff <= DATA_RST;
      lanes_ff <= LANES_NONE;
    end else if (take && !no_lane) begin
      addr_ff <= req.addr;
      dout_ff <= req.wdata & lane_mask(req.lane_en); // see R07 R08
      lanes_ff <= req.lane_en;
    end
  end

  // read capture after access time plus synchroniser latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rdata_ff <= DATA_RST;
    end else begin
      rsp_valid_ff <= rd_done && !brownout;
      if (rd_done) begin
        rdata_ff <= dq_s & rd_mask; // see R06
      end
    end
  end

  assign mem_ctl = ctl_ff;
  assign mem_addr = addr_ff;
  assign dq_out = dout_ff;
  assign dq_oe_n = drive_n_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;

  // helper: cycles since the last select fall, saturating
  logic [7:0] since_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      since_ff <= 8'hFF;
    end else if (ctl_ff.sel_n && !nxt_state[1] && state_ff == ST_IDLE && take && !no_lane) begin
      since_ff <= 8'h00;
    end else if (since_ff != 8'hFF) begin
      since_ff <= since_ff + 8'h01;
    end
  end

  // pin checks; a brownout aborts whatever access is in flight, so those checks drop out
  chk_quiet_startup: assert property (@(posedge sys_clk) disable iff (rst) // see R11
    in_init |=> (mem_ctl.sel_n && mem_ctl.wr_n) || !in_init)
    else $error("memory selected during startup wait");
  chk_reset_high: assert property (@(posedge sys_clk) // see R12
    rst |=> mem_ctl.sel_n && mem_ctl.wr_n && dq_oe_n)
    else $error("select or strobe low after reset");
  chk_brownout_restart: assert property (@(posedge sys_clk) disable iff (rst) // see R13
    brownout |=> in_init && mem_ctl.sel_n && cnt_ff == '0)
    else $error("brownout did not restart startup wait");
  chk_cycle_spacing: assert property (@(posedge sys_clk) disable iff (rst) // see R14
    $fell(mem_ctl.sel_n) |-> $past(since_ff) >= 8'(CYCLE_CYC - 1))
    else $error("accesses closer than minimum cycle");
  chk_wr_pulse_len: assert property (@(posedge sys_clk) disable iff (rst || brownout) // see R15
    $fell(mem_ctl.wr_n) |-> (!mem_ctl.wr_n && !mem_ctl.sel_n)[*3])
    else $error("write pulse shorter than required");
  chk_wr_stable: assert property (@(posedge sys_clk) disable iff (rst || brownout) // see R15
    (!mem_ctl.wr_n && !mem_ctl.sel_n) |=> $stable(mem_addr) && $stable(dq_out) && !dq_oe_n)
    else $error("address or data moved during write overlap");
  chk_no_contention: assert property (@(posedge sys_clk) disable iff (rst) // see R09
    !mem_ctl.oe_n |-> dq_oe_n)
    else $error("controller drives lanes while output gate low");
  chk_lane_access: assert property (@(posedge sys_clk) disable iff (rst) // see R03
    !mem_ctl.sel_n |-> !(mem_ctl.lower_lane_select_low && mem_ctl.upper_lane_select_low))
    else $error("select low with both lanes off");
  chk_read_reply: assert property (@(posedge sys_clk) disable iff (rst || brownout) // see R06
    $fell(mem_ctl.oe_n) |-> ##8 rsp_valid)
    else $error("read response not on time");
  chk_startup_len: assert property (@(posedge sys_clk) disable iff (rst) // see R11
    $rose(mem_ready) |-> $past(cnt_ff) == STARTUP_LAST)
    else $error("startup wait ended early");
  chk_read_gate: assert property (@(posedge sys_clk) disable iff (rst) // see R06
    !mem_ctl.oe_n |-> state_ff == ST_READ)
    else $error("output gate low outside a read");
  chk_rsp_pulse: assert property (@(posedge sys_clk) disable iff (rst) // see R06
    rsp_valid |=> !rsp_valid)
    else $error("read response longer than one cycle");

  // main scenarios

  cov_write: cover property (@(posedge sys_clk) disable iff (rst) $fell(mem_ctl.wr_n));
  cov_read: cover property (@(posedge sys_clk) disable iff (rst) rsp_valid);
  cov_byte_write: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(mem_ctl.wr_n) && mem_ctl.upper_lane_select_low);
  cov_brownout: cover property (@(posedge sys_clk) disable iff (rst) brownout);
  cov_byte_read: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(mem_ctl.oe_n) && mem_ctl.upper_lane_select_low);
endmodule
`default_nettype wire

//--- tb/anwm_mem_model.sv
// Purpose: behavioural 64K x 16 async word memory facing the host controller
// Assumes: zero-delay pins; host_oe_n low while the host drives the lanes
// Notes: released lanes show a pattern that flips every cycle
`timescale 1ns/1ps
`default_nettype none
module anwm_mem_model
  import anwm_pkg::*;
(
  // clock, only for the released-lane pattern
  input wire logic sys_clk,
  // supply and control pins
  input wire logic supply_ok,
  input wire anwm_ctl_t ctl,
  input wire logic [ADDR_W-1:0] addr,
  // host side of the data lanes
  input wire logic [DATA_W-1:0] host_dq,
  input wire logic host_oe_n,
  // resolved lane level
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] flt_ff = 16'h5A5A;
  logic [DATA_W-1:0] lat_d;
  logic [ADDR_W-1:0] lat_a;
  logic [1:0] lat_l;
  // read decode; deselected or gated off floats both lanes
  wire logic rd = !ctl.sel_n && !ctl.oe_n && ctl.wr_n;
  wire logic rd_lo = rd && !ctl.lower_lane_select_low;
  wire logic rd_hi = rd && !ctl.upper_lane_select_low;
  wire logic wr_on = !ctl.sel_n && !ctl.wr_n;
  // a stale level on a released lane would hide a late sample
  always @(posedge sys_clk) flt_ff <= ~flt_ff;
  always_comb begin
    dq = flt_ff;
    if (!host_oe_n) begin
      dq = host_dq;
    end else begin
      if (rd_lo) dq[7:0] = mem[addr][7:0];
      if (rd_hi) dq[15:8] = mem[addr][15:8];
    end
  end
  // pins move together at the end of a write, so keep the overlap values
  always @* begin
    if (!ctl.sel_n && !ctl.wr_n) begin
      lat_a = addr;
      lat_d = dq;
      lat_l = {!ctl.upper_lane_select_low, !ctl.lower_lane_select_low};
    end
  end
  always @(negedge wr_on) begin
    if (supply_ok) begin
      if (lat_l[0]) mem[lat_a][7:0] <= lat_d[7:0];
      if (lat_l[1]) mem[lat_a][15:8] <= lat_d[15:8];
    end
  end
endmodule
`default_nettype wire

//--- tb/anwm_host_test.sv
// Purpose: self-checking bench for the async word memory host controller
// Assumes: shortened startup count, one request at a time
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module anwm_host_test;
  import anwm_pkg::*;
  localparam int SU = 20;
  logic sys_clk, rst, supply_ok, req_valid, req_ready, rsp_valid, mem_ready, dq_oe_n;
  anwm_req_t req;
  anwm_ctl_t mem_ctl;
  logic [DATA_W-1:0] rsp_rdata, dq_out, dq_in, rd;
  logic [ADDR_W-1:0] mem_addr;
  int err_count, n_tests;
  anwm_host #(.STARTUP_CYCLES(SU)) dut (.sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_ready(mem_ready), .mem_ctl(mem_ctl), .mem_addr(mem_addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  anwm_mem_model mem (.sys_clk(sys_clk), .supply_ok(supply_ok), .ctl(mem_ctl), .addr(mem_addr),
    .host_dq(dq_out), .host_oe_n(dq_oe_n), .dq(dq_in));
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request; a read waits for its answer and checks the latency
  task automatic go(logic w, logic [1:0] ln, logic [15:0] a, logic [15:0] d);
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 200) begin
      @(posedge sys_clk); #1; i++;
    end
    chk("req_ready", 16'h0001, {15'h0, req_ready});
    req = '{w, ln, a, d};
    req_valid = 1;
    @(posedge sys_clk); #1;
    req_valid = 0;
    if (!w && ln != 2'h0) begin
      i = 0;
      while (rsp_valid !== 1'b1 && i < 30) begin
        @(posedge sys_clk); #1; i++;
      end
      chk("rd_latency", 16'(ACCESS_CYC + SYNC_LAT_CYC), 16'(i));
      rd = rsp_rdata;
    end
  endtask
  // controls must stay idle until the startup wait is over
  task automatic wait_up();
    int n;
    n = 0;
    while (mem_ready !== 1'b1 && n < 200) begin
      chk("ctl_idle", 16'(CTL_IDLE), 16'(mem_ctl));
      @(posedge sys_clk); #1; n++;
    end
    chk("startup_long", 16'h0001, 16'(n >= SU));
    chk("ready_up", 16'h0001, {15'h0, mem_ready});
  endtask
  task automatic t_word();
    go(1, 2'h3, 16'hFFFF, 16'hA55A);
    go(1, 2'h3, 16'h0000, 16'h1234);
    go(0, 2'h3, 16'hFFFF, 16'h0000);
    chk("word_hi_addr", 16'hA55A, rd);
    go(0, 2'h3, 16'h0000, 16'h0000);
    chk("word_lo_addr", 16'h1234, rd);
    $display("test word done");
  endtask
  task automatic t_bytes();
    go(1, 2'h1, 16'hFFFF, 16'h77C3);
    go(0, 2'h3, 16'hFFFF, 16'h0000);
    chk("lower_write", 16'hA5C3, rd);
    go(1, 2'h2, 16'hFFFF, 16'h3C77);
    go(0, 2'h3, 16'hFFFF, 16'h0000);
    chk("upper_write", 16'h3CC3, rd);
    go(0, 2'h1, 16'hFFFF, 16'h0000);
    chk("lower_read", 16'h00C3, rd);
    go(0, 2'h2, 16'hFFFF, 16'h0000);
    chk("upper_read", 16'h3C00, rd);
    $display("test bytes done");
  endtask
  task automatic t_none();
    go(1, 2'h0, 16'h0000, 16'hFFFF);
    repeat (8) begin
      chk("no_access_ctl", 16'(CTL_IDLE), 16'(mem_ctl));
      @(posedge sys_clk); #1;
    end
    go(0, 2'h3, 16'h0000, 16'h0000);
    chk("no_access_data", 16'h1234, rd);
    $display("test no lanes done");
  endtask
  task automatic t_brown();
    int i;
    supply_ok = 0;
    i = 0;
    while (mem_ready !== 1'b0 && i < 20) begin
      @(posedge sys_clk); #1; i++;
    end
    chk("brown_ready", 16'h0000, {15'h0, req_ready});
    chk("brown_state", 16'h0000, {15'h0, mem_ready});
    chk("brown_ctl", 16'(CTL_IDLE), 16'(mem_ctl));
    repeat (4) @(posedge sys_clk);
    #1 supply_ok = 1;
    wait_up();
    go(0, 2'h3, 16'hFFFF, 16'h0000);
    chk("kept_word", 16'h3CC3, rd);
    $display("test brownout done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  initial begin
    rst = 1;
    supply_ok = 1;
    req_valid = 0;
    req = '0;
    err_count = 0;
    n_tests = 0;
    rd = 16'h0000;
    repeat (6) @(posedge sys_clk);
    #1 rst = 0;
    wait_up();
    t_word();
    t_bytes();
    t_none();
    t_brown();
    final_report();
  end
endmodule
`default_nettype wire
